// >>> include/ifd_pkg.sv
// shared constants, types and state layout of the instruction format decoder
package ifd_pkg;

  // data path widths
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned PC_W    = 16;
  localparam int unsigned REL_W   = 12;
  localparam int unsigned RADDR_W = 9;
  localparam int unsigned LEN_W   = 2;

  // flag register location, layout and reset value
  localparam logic [7:0] FLAGS_ADDR    = 8'hf7;
  localparam logic [7:0] FLAGS_RESET   = 8'h02;
  localparam logic [7:0] FLAGS_WR_MASK = 8'hd7;
  localparam int unsigned FLG_PGM_HI   = 7;
  localparam int unsigned FLG_PGM_LO   = 6;
  localparam int unsigned FLG_BANK     = 4;
  localparam int unsigned FLG_CARRY    = 2;
  localparam int unsigned FLG_ZERO     = 1;
  localparam int unsigned FLG_GIE      = 0;

  // system control register touched by halt
  localparam logic [7:0] SCR0_ADDR = 8'hff;

  // opcodes with behaviour of their own in this block
  localparam logic [7:0] OPC_SSC    = 8'h00;
  localparam logic [7:0] OPC_NOP    = 8'h40;
  localparam logic [7:0] OPC_HALT   = 8'h30;
  localparam logic [7:0] OPC_PUSH_A = 8'h08;
  localparam logic [7:0] OPC_PUSH_X = 8'h10;
  localparam logic [7:0] OPC_AND_F  = 8'h70;
  localparam logic [7:0] OPC_OR_F   = 8'h71;
  localparam logic [7:0] OPC_XOR_F  = 8'h72;
  localparam logic [7:0] OPC_LONG_CALL  = 8'h7c;
  localparam logic [7:0] OPC_LONG_JUMP   = 8'h7d;
  localparam logic [7:0] OPC_MOVDD  = 8'h5f;
  localparam logic [3:0] OPC_REL_MIN = 4'h8;

  // instruction lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE   = 2'd1;
  localparam logic [LEN_W-1:0] LEN_TWO   = 2'd2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'd3;

  // interrupt entry point (arbitrary default)
  localparam logic [PC_W-1:0] IRQ_VECTOR = 16'h0004;
  localparam logic [PC_W-1:0] PC_RESET   = 16'h0000;

  // the seven instruction formats
  typedef enum logic [2:0] {
    FMT_OPC      = 3'b000,
    FMT_REL      = 3'b001,
    FMT_IMM      = 3'b010,
    FMT_ADR      = 3'b011,
    FMT_ABS      = 3'b100,
    FMT_ADR_IMM  = 3'b101,
    FMT_ADR_ADR  = 3'b110
  } ifd_fmt_e;

  // where a one-byte instruction leaves its result
  typedef enum logic [1:0] {
    CLS_NONE = 2'b00,
    CLS_PUSH = 2'b01,
    CLS_HALT = 2'b10,
    CLS_CORE = 2'b11
  } ifd_cls_e;

  // sequencer states
  typedef enum logic [2:0] {
    ST_FETCH  = 3'b000,
    ST_WAIT   = 3'b001,
    ST_ISSUE  = 3'b010,
    ST_EXEC   = 3'b011,
    ST_IRQ    = 3'b100,
    ST_IRQCLR = 3'b101
  } ifd_state_e;

  // one decoded instruction as handed to the execute side
  typedef struct packed {
    logic [BYTE_W-1:0] opcode;
    logic [BYTE_W-1:0] byte1;
    logic [BYTE_W-1:0] byte2;
    ifd_fmt_e          fmt;
    logic [LEN_W-1:0]  len;
    ifd_cls_e          cls;
  } ifd_instr_s;

  // complete state of the decoder
  typedef struct packed {
    ifd_state_e        state;
    logic [LEN_W-1:0]  idx;
    ifd_instr_s        instr;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   rel_target;
    logic [BYTE_W-1:0] flags;
    logic [PC_W-1:0]   pm_addr;
    logic              pm_rd;
    logic              instr_valid;
    logic              supervisory_rom_call;
    logic              halt_wr;
    logic              stack_wr;
    logic [BYTE_W-1:0] stack_data;
    logic              irq_ack;
    logic [BYTE_W-1:0] reg_rdata;
    logic              reg_rvalid;
  } ifd_state_s;

endpackage

// >>> src/ifd_format_dec.sv
// opcode to format, length and result class lookup
`timescale 1ns/10ps
module ifd_format_dec
  import ifd_pkg::*;
(
  input  wire logic [BYTE_W-1:0] opc,
  output ifd_fmt_e               fmt,
  output logic [LEN_W-1:0]       len,
  output ifd_cls_e               cls
);

  // classify by opcode, first byte alone decides the length
  always_comb begin
    fmt = FMT_ADR;
    cls = CLS_CORE;
    if (opc[7:4] >= OPC_REL_MIN) begin
      fmt = FMT_REL;
    end else if (opc == OPC_LONG_JUMP || opc == OPC_LONG_CALL) begin
      fmt = FMT_ABS;
    end else if (opc == OPC_MOVDD) begin
      fmt = FMT_ADR_ADR;
    end else if (opc == OPC_SSC || opc == OPC_NOP) begin
      fmt = FMT_OPC;
      cls = CLS_NONE;
    end else if (opc == OPC_PUSH_A || opc == OPC_PUSH_X) begin
      fmt = FMT_OPC;
      cls = CLS_PUSH;
    end else if (opc == OPC_HALT) begin
      fmt = FMT_OPC;
      cls = CLS_HALT;
    end else begin
      case (opc)
        8'h18, 8'h20, 8'h28, 8'h4b, 8'h4e, 8'h5b, 8'h5c, 8'h64, 8'h67,
        8'h6a, 8'h6d, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
        8'h7e, 8'h7f: fmt = FMT_OPC;
        8'h01, 8'h09, 8'h11, 8'h19, 8'h21, 8'h29, 8'h31, 8'h38, 8'h39,
        8'h50, 8'h57, OPC_AND_F, OPC_OR_F, OPC_XOR_F: fmt = FMT_IMM;
        8'h06, 8'h07, 8'h0e, 8'h0f, 8'h16, 8'h17, 8'h1e, 8'h1f, 8'h26,
        8'h27, 8'h2e, 8'h2f, 8'h36, 8'h37, 8'h3c, 8'h3d, 8'h41, 8'h42,
        8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h55,
        8'h56, 8'h62, 8'h63: fmt = FMT_ADR_IMM;
        // every other opcode carries one address byte
        default: fmt = FMT_ADR;
      endcase
    end
  end

  always_comb begin
    case (fmt)
      FMT_OPC:                           len = LEN_ONE;
      FMT_REL, FMT_IMM, FMT_ADR:         len = LEN_TWO;
      FMT_ABS, FMT_ADR_IMM, FMT_ADR_ADR: len = LEN_THREE;
      default:                           len = LEN_ONE;
    endcase
  end

endmodule

// >>> src/ifd_core.sv
// instruction fetch, format decode, flag register and interrupt entry
//
// How it works
// - seven formats, length from first byte
// - bytes fetched over separate program bus
// - one-byte form is opcode only
// - nop and supervisory call only advance PC
// - supervisory call hands control to ROM
// - pushes write RAM, bump stack pointer
// - halt alone writes system control register
// - other one-byte ops update core registers
// - short branch: 12-bit signed offset
// - immediate form: opcode plus constant
// - address form: opcode plus address byte
// - long jump/call: 16-bit target, high first
// - three bytes: opcode, address, constant
// - direct move: opcode, destination, source
// - flags at F7h in either bank
// - whole flag byte written only by flag logic ops
// - page mode steers RAM address forming
// - bank bit is ninth register address bit
// - carry and zero follow results and logic
// - enable set samples request each instruction
// - interrupt pushes flags, then clears enable
`timescale 1ns/10ps
module ifd_core
  import ifd_pkg::*;
#(
  parameter logic [PC_W-1:0] RESET_PC = PC_RESET
)
(
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                CE,
  output logic [PC_W-1:0]          PM_ADDR,
  output logic                     PM_RD,
  input  wire logic [BYTE_W-1:0]   PM_RDATA,
  input  wire logic                PM_ACK,
  output logic                     INSTR_VALID,
  output ifd_instr_s               INSTR,
  output logic [PC_W-1:0]          INSTR_PC,
  output logic [PC_W-1:0]          REL_TARGET,
  input  wire logic                EXE_DONE,
  input  wire logic                BR_TAKEN,
  input  wire logic [PC_W-1:0]     BR_TARGET,
  input  wire logic                RES_C_WE,
  input  wire logic                RES_Z_WE,
  input  wire logic                RES_CARRY,
  input  wire logic                RES_ZERO,
  input  wire logic                IRQ,
  output logic                     IRQ_ACK,
  output logic                     STACK_WR,
  output logic [BYTE_W-1:0]        STACK_DATA,
  input  wire logic                REG_RD,
  input  wire logic [RADDR_W-1:0]  REG_ADDR,
  output logic [BYTE_W-1:0]        REG_RDATA,
  output logic                     REG_RVALID,
  output logic [BYTE_W-1:0]        FLAGS,
  output logic [1:0]               PAGE_MODE,
  output logic                     REG_BANK,
  output logic                     SUPERVISORY_ROM_CALL,
  output logic                     HALT_WR
);

  // elaboration check on the start address width
  if ($bits(RESET_PC) != PC_W) begin : g_bad_pc
    $error("reset pc width must match the program counter");
  end

  ifd_state_s st_r;
  ifd_state_s st_nxt;

  ifd_fmt_e         dec_fmt;
  logic [LEN_W-1:0] dec_len;
  ifd_cls_e         dec_cls;

  logic [PC_W-1:0]   pc_seq;
  logic [PC_W-1:0]   abs_target;
  logic [PC_W-1:0]   rel_calc;
  logic [BYTE_W-1:0] flags_upd;
  logic              is_flag_op;

  // first-byte decode straight off the program bus
  ifd_format_dec u_dec (
    .opc (PM_RDATA),
    .fmt (dec_fmt),
    .len (dec_len),
    .cls (dec_cls)
  );

  assign pc_seq = st_r.pc + PC_W'(st_r.instr.len);

  assign abs_target = {st_r.instr.byte1, st_r.instr.byte2};

  // signed 12-bit offset from the word after the opcode byte
  assign rel_calc = st_r.pc + PC_W'(1)
                  + {{(PC_W-REL_W){st_r.instr.opcode[3]}},
                     st_r.instr.opcode[3:0], st_r.instr.byte1};

  // only the three flag logic ops may write the flag byte
  assign is_flag_op = (st_r.instr.opcode == OPC_AND_F) ||
                      (st_r.instr.opcode == OPC_OR_F)  ||
                      (st_r.instr.opcode == OPC_XOR_F);

  // flag value after the instruction retires
  always_comb begin
    flags_upd = st_r.flags;
    if (is_flag_op) begin
      case (st_r.instr.opcode)
        OPC_AND_F: flags_upd = st_r.flags & st_r.instr.byte1;
        OPC_OR_F:  flags_upd = st_r.flags | st_r.instr.byte1;
        OPC_XOR_F: flags_upd = st_r.flags ^ st_r.instr.byte1;
        default:   flags_upd = st_r.flags;
      endcase
      // reserved bits never hold a one
      flags_upd = flags_upd & FLAGS_WR_MASK;
    end else begin
      // carry and zero from the execute result
      if (RES_C_WE) begin
        flags_upd[FLG_CARRY] = RES_CARRY;
      end
      if (RES_Z_WE) begin
        flags_upd[FLG_ZERO] = RES_ZERO;
      end
    end
  end

  // next-state logic for the whole block
  always_comb begin
    st_nxt             = st_r;
    st_nxt.instr_valid = 1'b0;
    st_nxt.supervisory_rom_call   = 1'b0;
    st_nxt.halt_wr     = 1'b0;
    st_nxt.stack_wr    = 1'b0;
    st_nxt.irq_ack     = 1'b0;
    st_nxt.reg_rvalid  = 1'b0;

    // flag byte readable at F7h whatever the bank bit
    if (REG_RD) begin
      st_nxt.reg_rvalid = 1'b1;
      if (REG_ADDR[BYTE_W-1:0] == FLAGS_ADDR) begin
        st_nxt.reg_rdata = st_r.flags;
      end else begin
        st_nxt.reg_rdata = '0;
      end
    end

    case (st_r.state)
      // request next byte on the program bus
      ST_FETCH: begin
        st_nxt.pm_rd   = 1'b1;
        st_nxt.pm_addr = st_r.pc + PC_W'(st_r.idx);
        st_nxt.state   = ST_WAIT;
      end
      // capture a byte when program memory answers
      ST_WAIT: begin
        if (PM_ACK) begin
          st_nxt.pm_rd = 1'b0;
          case (st_r.idx)
            // opcode byte fixes format and length
            2'd0: begin
              st_nxt.instr.opcode = PM_RDATA;
              st_nxt.instr.byte1  = '0;
              st_nxt.instr.byte2  = '0;
              st_nxt.instr.fmt    = dec_fmt;
              st_nxt.instr.len    = dec_len;
              st_nxt.instr.cls    = dec_cls;
            end
            2'd1:    st_nxt.instr.byte1 = PM_RDATA;
            default: st_nxt.instr.byte2 = PM_RDATA;
          endcase
          // single-byte forms stop after the opcode
          if ((st_r.idx == 2'd0 && dec_len == LEN_ONE) ||
              (st_r.idx != 2'd0 && st_r.idx + 2'd1 == st_r.instr.len)) begin
            st_nxt.idx   = '0;
            st_nxt.state = ST_ISSUE;
          end else begin
            st_nxt.idx   = st_r.idx + 2'd1;
            st_nxt.state = ST_FETCH;
          end
        end
      end
      // hand the instruction over for one cycle
      ST_ISSUE: begin
        st_nxt.instr_valid = 1'b1;
        st_nxt.rel_target  = rel_calc;
        if (st_r.instr.opcode == OPC_SSC) begin
          st_nxt.supervisory_rom_call = 1'b1;
        end
        // halt drives the system control write
        if (st_r.instr.cls == CLS_HALT) begin
          st_nxt.halt_wr = 1'b1;
        end
        st_nxt.state = ST_EXEC;
      end
      // wait for the execute side to retire it
      ST_EXEC: begin
        if (EXE_DONE) begin
          st_nxt.flags = flags_upd;
          if (st_r.instr.fmt == FMT_ABS) begin
            st_nxt.pc = abs_target;
          end else if (BR_TAKEN && st_r.instr.cls != CLS_NONE) begin
            st_nxt.pc = BR_TARGET;
          // plain advance, the only effect of nop
          end else begin
            st_nxt.pc = pc_seq;
          end
          // request sampled once per instruction when enabled
          if (flags_upd[FLG_GIE] && IRQ) begin
            st_nxt.state = ST_IRQ;
          end else begin
            st_nxt.state = ST_FETCH;
          end
        end
      end
      ST_IRQ: begin
        st_nxt.stack_wr   = 1'b1;
        st_nxt.stack_data = st_r.flags;
        st_nxt.irq_ack    = 1'b1;
        st_nxt.state      = ST_IRQCLR;
      end
      // then drop the enable and enter the handler
      ST_IRQCLR: begin
        st_nxt.flags[FLG_GIE] = 1'b0;
        st_nxt.pc             = IRQ_VECTOR;
        st_nxt.state          = ST_FETCH;
      end
      default: begin
        st_nxt.state = ST_FETCH;
        st_nxt.idx   = '0;
      end
    endcase
  end

  // state register with clock enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r            <= '0;
      st_r.state      <= ST_FETCH;
      st_r.instr.fmt  <= FMT_OPC;
      st_r.instr.cls  <= CLS_NONE;
      st_r.pc         <= RESET_PC;
      st_r.flags      <= FLAGS_RESET;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign PM_ADDR     = st_r.pm_addr;
  assign PM_RD       = st_r.pm_rd;
  assign INSTR_VALID = st_r.instr_valid;
  assign INSTR       = st_r.instr;
  assign INSTR_PC    = st_r.pc;
  assign REL_TARGET  = st_r.rel_target;
  assign IRQ_ACK     = st_r.irq_ack;
  assign STACK_WR    = st_r.stack_wr;
  assign STACK_DATA  = st_r.stack_data;
  assign REG_RDATA   = st_r.reg_rdata;
  assign REG_RVALID  = st_r.reg_rvalid;
  assign FLAGS       = st_r.flags;
  assign SUPERVISORY_ROM_CALL   = st_r.supervisory_rom_call;
  assign HALT_WR     = st_r.halt_wr;

  // page mode out to the RAM address former
  assign PAGE_MODE = st_r.flags[FLG_PGM_HI:FLG_PGM_LO];
  // bank bit extends register addresses to nine bits
  assign REG_BANK  = st_r.flags[FLG_BANK];

endmodule

// >>> tb/ifd_chk.sv
// concurrent checks on the decoder core ports
`timescale 1ns/10ps
module ifd_chk
  import ifd_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic [PC_W-1:0]    PM_ADDR,
  input wire logic               PM_RD,
  input wire logic               PM_ACK,
  input wire logic               INSTR_VALID,
  input wire ifd_instr_s         INSTR,
  input wire logic [PC_W-1:0]    INSTR_PC,
  input wire logic [PC_W-1:0]    REL_TARGET,
  input wire logic               EXE_DONE,
  input wire logic               IRQ,
  input wire logic               IRQ_ACK,
  input wire logic               STACK_WR,
  input wire logic [BYTE_W-1:0]  STACK_DATA,
  input wire logic               REG_RD,
  input wire logic [RADDR_W-1:0] REG_ADDR,
  input wire logic [BYTE_W-1:0]  REG_RDATA,
  input wire logic               REG_RVALID,
  input wire logic [BYTE_W-1:0]  FLAGS,
  input wire logic [1:0]         PAGE_MODE,
  input wire logic               REG_BANK,
  input wire logic               SUPERVISORY_ROM_CALL,
  input wire logic               HALT_WR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // length expected from the decoded format
  logic [LEN_W-1:0] len_exp;
  always_comb begin
    case (INSTR.fmt)
      FMT_OPC: len_exp = LEN_ONE;
      FMT_REL, FMT_IMM, FMT_ADR: len_exp = LEN_TWO;
      default: len_exp = LEN_THREE;
    endcase
  end
  property p_len;
    INSTR_VALID |-> INSTR.len == len_exp;
  endproperty
  a_len: assert property (p_len) else $error("length does not match format");
  property p_pm_hold;
    PM_RD && !PM_ACK |=> PM_RD && $stable(PM_ADDR);
  endproperty
  a_pm_hold: assert property (p_pm_hold) else $error("fetch dropped early");
  property p_pm_drop;
    PM_RD && PM_ACK |=> !PM_RD;
  endproperty
  a_pm_drop: assert property (p_pm_drop) else $error("fetch held after ack");
  property p_rel;
    INSTR_VALID && INSTR.fmt == FMT_REL |-> REL_TARGET ==
      INSTR_PC + 16'h0001 + {{4{INSTR.opcode[3]}}, INSTR.opcode[3:0], INSTR.byte1};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_fields;
    PAGE_MODE == FLAGS[7:6] && REG_BANK == FLAGS[4] && FLAGS[5] == 1'b0 && FLAGS[3] == 1'b0;
  endproperty
  a_fields: assert property (p_fields) else $error("flag fields wrong");
  property p_reg_rd;
    REG_RD |=> REG_RVALID && REG_RDATA ==
      (($past(REG_ADDR[7:0]) == FLAGS_ADDR) ? $past(FLAGS) : 8'h00);
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("register read wrong");
  property p_flag_src;
    !$stable(FLAGS) |-> $past(EXE_DONE) || $past(IRQ_ACK);
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flags changed unasked");
  property p_irq;
    IRQ_ACK |-> STACK_WR && STACK_DATA == FLAGS && FLAGS[FLG_GIE]
      && $past(IRQ, 2) && $past(EXE_DONE, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt entry wrong");
  property p_gie_clr;
    IRQ_ACK |=> FLAGS == ($past(STACK_DATA) & 8'hfe);
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("enable not cleared");
  property p_issue;
    SUPERVISORY_ROM_CALL || HALT_WR |-> (SUPERVISORY_ROM_CALL ? INSTR.opcode == OPC_SSC : INSTR.opcode == OPC_HALT);
  endproperty
  a_issue: assert property (p_issue) else $error("call or halt pulse wrong");
endmodule

// >>> tb/ifd_pm_model.sv
// program memory model answering fetches after a selectable wait
`timescale 1ns/10ps
module ifd_pm_model
  import ifd_pkg::*;
(
  input  wire logic            CLK,
  input  wire logic            RST,
  input  wire logic            SLOW,
  input  wire logic [PC_W-1:0] PM_ADDR,
  input  wire logic            PM_RD,
  output logic [BYTE_W-1:0]    PM_RDATA,
  output logic                 PM_ACK
);
  logic [BYTE_W-1:0] mem [512];
  logic [BYTE_W-1:0] last_r;
  logic [1:0]        wait_r;
  initial {PM_ACK, PM_RDATA, last_r, wait_r} = '0;
  // own program bus, idle data inverted
  always @(posedge CLK) begin
    if (RST || !PM_RD || PM_ACK) begin
      PM_ACK   <= 1'b0;
      wait_r   <= 2'h0;
      PM_RDATA <= ~last_r;
    end else if (wait_r == (SLOW ? 2'h3 : 2'h0)) begin
      PM_ACK   <= 1'b1;
      PM_RDATA <= mem[PM_ADDR[8:0]];
      last_r   <= mem[PM_ADDR[8:0]];
    end else begin
      wait_r   <= wait_r + 2'h1;
    end
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the instruction format decoder core
`timescale 1ns/10ps
module tb;
  import ifd_pkg::*;
  logic               CLK, RST, CE, PM_RD, PM_ACK, INSTR_VALID, EXE_DONE, BR_TAKEN, IRQ;
  logic               RES_C_WE, RES_Z_WE, RES_CARRY, RES_ZERO, IRQ_ACK, STACK_WR, REG_RD;
  logic               REG_RVALID, REG_BANK, SUPERVISORY_ROM_CALL, HALT_WR, slow, vld_seen;
  logic [PC_W-1:0]    PM_ADDR, INSTR_PC, REL_TARGET, BR_TARGET;
  logic [BYTE_W-1:0]  PM_RDATA, STACK_DATA, REG_RDATA, FLAGS;
  logic [RADDR_W-1:0] REG_ADDR;
  logic [1:0]         PAGE_MODE;
  ifd_instr_s         INSTR;
  int                 error_cnt, n_checks, cyc, supervisory_rom_n, halt_n, ack_n, k;
  logic [7:0]         prog [20] = '{8'h40, 8'h08, 8'h30, 8'h00, 8'h71, 8'hd7, 8'h72, 8'h03,
    8'h70, 8'h51, 8'h5a, 8'h33, 8'h5f, 8'h11, 8'h22, 8'h8f, 8'hf0, 8'h7d, 8'h01, 8'h00};

  ifd_core dut_u (.CLK, .RST, .CE, .PM_ADDR, .PM_RD, .PM_RDATA, .PM_ACK, .INSTR_VALID, .INSTR,
    .INSTR_PC, .REL_TARGET, .EXE_DONE, .BR_TAKEN, .BR_TARGET, .RES_C_WE, .RES_Z_WE, .RES_CARRY,
    .RES_ZERO, .IRQ, .IRQ_ACK, .STACK_WR, .STACK_DATA, .REG_RD, .REG_ADDR, .REG_RDATA,
    .REG_RVALID, .FLAGS, .PAGE_MODE, .REG_BANK, .SUPERVISORY_ROM_CALL, .HALT_WR);
  ifd_pm_model pm_u (.CLK, .RST, .SLOW(slow), .PM_ADDR, .PM_RD, .PM_RDATA, .PM_ACK);

  always #4 CLK = ~CLK;

  // issue flag, pulse counters and hang limit
  always @(posedge CLK) begin
    if (INSTR_VALID === 1'b1) vld_seen <= 1'b1;
    if (SUPERVISORY_ROM_CALL === 1'b1) supervisory_rom_n++;
    if (HALT_WR === 1'b1) halt_n++;
    if (IRQ_ACK === 1'b1) ack_n++;
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // flag register read through the register port
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    chk({7'h00, REG_RVALID, REG_RDATA}, {8'h01, e});
  endtask

  // wait for one issued instruction, compare it, then retire it
  task automatic step(input logic [15:0] pc, input logic [23:0] ib, input logic [1:0] ln,
                      input ifd_fmt_e f, input ifd_cls_e c, input logic [4:0] res,
                      input logic [7:0] fl);
    k = 0;
    while (vld_seen !== 1'b1 && k < 60) begin
      @(posedge CLK);
      #1;
      k++;
    end
    chk(16'(vld_seen), 16'h0001);
    vld_seen = 1'b0;
    chk(INSTR_PC, pc);
    chk({INSTR.opcode, 6'h00, INSTR.len}, {ib[23:16], 6'h00, ln});
    chk(16'(INSTR.fmt), 16'(f));
    if (ln == LEN_ONE) chk(16'(INSTR.cls), 16'(c));
    if (ln != LEN_ONE) chk(16'(INSTR.byte1), 16'(ib[15:8]));
    if (ln == LEN_THREE) chk(16'(INSTR.byte2), 16'(ib[7:0]));
    @(negedge CLK);
    {BR_TAKEN, RES_C_WE, RES_CARRY, RES_Z_WE, RES_ZERO} = res;
    EXE_DONE = 1'b1;
    @(negedge CLK);
    {EXE_DONE, BR_TAKEN, RES_C_WE, RES_CARRY, RES_Z_WE, RES_ZERO} = '0;
    chk(16'(FLAGS), 16'(fl));
  endtask

  initial begin
    {CLK, CE, EXE_DONE, BR_TAKEN, IRQ, REG_RD, slow, vld_seen} = '0;
    {RES_C_WE, RES_Z_WE, RES_CARRY, RES_ZERO} = '0;
    RST = 1'b1;
    CE = 1'b1;
    BR_TARGET = 16'h0033;
    REG_ADDR = 9'h000;
    // long target stored high byte first
    for (int i = 0; i < 20; i++) pm_u.mem[i] = prog[i];
    pm_u.mem[256] = 8'h71;
    pm_u.mem[257] = 8'h01;
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    rd(9'h0f7, 8'h02);
    rd(9'h1f7, 8'h02);
    rd(9'h0fe, 8'h00);
    step(16'h0000, 24'h400000, LEN_ONE, FMT_OPC, CLS_NONE, 5'h00, 8'h02);
    step(16'h0001, 24'h080000, LEN_ONE, FMT_OPC, CLS_PUSH, 5'h00, 8'h02);
    step(16'h0002, 24'h300000, LEN_ONE, FMT_OPC, CLS_HALT, 5'h00, 8'h02);
    step(16'h0003, 24'h000000, LEN_ONE, FMT_OPC, CLS_NONE, 5'h10, 8'h02);
    step(16'h0004, 24'h71d700, LEN_TWO, FMT_IMM, CLS_NONE, 5'h00, 8'hd7);
    slow = 1'b1;
    step(16'h0006, 24'h720300, LEN_TWO, FMT_IMM, CLS_NONE, 5'h00, 8'hd4);
    step(16'h0008, 24'h705100, LEN_TWO, FMT_IMM, CLS_NONE, 5'h00, 8'h50);
    rd(9'h1f7, 8'h50);
    chk(16'(PAGE_MODE), 16'h0001);
    chk(16'(REG_BANK), 16'h0001);
    IRQ = 1'b1;
    step(16'h000a, 24'h5a3300, LEN_TWO, FMT_ADR, CLS_NONE, 5'h0e, 8'h54);
    step(16'h000c, 24'h5f1122, LEN_THREE, FMT_ADR_ADR, CLS_NONE, 5'h00, 8'h54);
    step(16'h000f, 24'h8ff000, LEN_TWO, FMT_REL, CLS_NONE, 5'h00, 8'h54);
    chk(REL_TARGET, 16'h0000);
    step(16'h0011, 24'h7d0100, LEN_THREE, FMT_ABS, CLS_NONE, 5'h10, 8'h54);
    step(16'h0100, 24'h710100, LEN_TWO, FMT_IMM, CLS_NONE, 5'h00, 8'h55);
    k = 0;
    while (IRQ_ACK !== 1'b1 && k < 8) begin
      @(posedge CLK);
      #1;
      k++;
    end
    chk({STACK_WR, 7'h00, STACK_DATA}, 16'h8055);
    @(posedge CLK);
    #1;
    chk(16'(FLAGS), 16'h0054);
    @(negedge CLK);
    IRQ = 1'b0;
    // code after the handler entry: address-constant form, then a one-byte core op
    pm_u.mem[6] = 8'h55;
    pm_u.mem[7] = 8'haa;
    pm_u.mem[8] = 8'h5c;
    pm_u.mem[9] = 8'h5b;
    step(IRQ_VECTOR, 24'h71d700, LEN_TWO, FMT_IMM, CLS_NONE, 5'h00, 8'hd7);
    step(16'h0006, 24'h55aa5c, LEN_THREE, FMT_ADR_IMM, CLS_NONE, 5'h00, 8'hd7);
    step(16'h0009, 24'h5b0000, LEN_ONE, FMT_OPC, CLS_CORE, 5'h00, 8'hd7);
    chk(16'(supervisory_rom_n), 16'h0001);
    chk(16'(halt_n), 16'h0001);
    chk(16'(ack_n), 16'h0001);
    summarize();
  end
endmodule

bind ifd_core ifd_chk chk_u (.CLK, .RST, .PM_ADDR, .PM_RD, .PM_ACK, .INSTR_VALID, .INSTR,
  .INSTR_PC, .REL_TARGET, .EXE_DONE, .IRQ, .IRQ_ACK, .STACK_WR, .STACK_DATA, .REG_RD,
  .REG_ADDR, .REG_RDATA, .REG_RVALID, .FLAGS, .PAGE_MODE, .REG_BANK, .SUPERVISORY_ROM_CALL, .HALT_WR);
